/* common/eeprom_regs.svh */
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define OPC_W 2
`define ADDR_W 8
`define DATA_W 16

// ****************************************************************
// Opcodes and sub-codes (top two address bits of the 00 group)
// ****************************************************************
`define OPC_SPECIAL 2'h0
`define OPC_WRITE 2'h1
`define OPC_READ 2'h2
`define OPC_ERASE 2'h3
`define SUB_DISABLE 2'h0
`define SUB_WRITE_ALL 2'h1
`define SUB_ERASE_ALL 2'h2
`define SUB_ENABLE 2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define SYS_CLK_PERIOD_NS 8
`define PROG_TIME_NS 4000000
`define PROG_CYCLES (`PROG_TIME_NS / `SYS_CLK_PERIOD_NS)

`endif

/* common/eeprom_pkg.sv */
package eeprom_pkg;

  typedef enum logic [2:0] {
    INS_NONE,
    INS_READ,
    INS_WRITE,
    INS_ERASE,
    INS_ENABLE,
    INS_DISABLE,
    INS_ERASE_ALL,
    INS_WRITE_ALL
  } ins_e;

endpackage

/* core/eeprom_store.sv */
`timescale 1ns/100ps
`include "eeprom_regs.svh"

module eeprom_store #(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES,
  parameter int unsigned ADDR_W = `ADDR_W,
  parameter int unsigned DATA_W = `DATA_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire eeprom_pkg::ins_e op,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  output logic busy
);

  localparam int unsigned TMR_W = $clog2(PROG_CYCLES + 1);
  localparam logic [TMR_W-1:0] CLEAR_AT = TMR_W'(PROG_CYCLES / 2);
  localparam logic [DATA_W-1:0] ONES = '1;
  localparam int unsigned DEPTH = 2 ** ADDR_W;

  logic [DATA_W-1:0] mem_r [DEPTH];
  logic [TMR_W-1:0] timer_r;
  logic busy_r;
  eeprom_pkg::ins_e op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;

  assign busy = busy_r;

  // ****************************************************************
  // Self-timed cycle, runs on sys_clk only
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      timer_r <= '0;
      op_r <= eeprom_pkg::INS_NONE;
      addr_r <= '0;
      data_r <= '0;
    end else if (start && !busy_r) begin
      busy_r <= 1'b1; // [R7]
      timer_r <= TMR_W'(PROG_CYCLES - 1);
      op_r <= op;
      addr_r <= addr;
      data_r <= data;
    end else if (busy_r) begin
      timer_r <= timer_r - 1'b1;
      if (timer_r == '0) begin
        busy_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Array: clear phase at mid cycle, store phase at the end
  // ****************************************************************
  // Power-on content is all ones so a fresh part reads as erased
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= ONES;
      end
    end else if (busy_r && timer_r == CLEAR_AT) begin
      if (op_r == eeprom_pkg::INS_WRITE || op_r == eeprom_pkg::INS_ERASE) begin
        mem_r[addr_r] <= ONES; // [R2] [R3] [R4]
      end else if (op_r == eeprom_pkg::INS_ERASE_ALL) begin
        for (int i = 0; i < DEPTH; i++) begin
          mem_r[i] <= ONES; // [R5]
        end
      end
    end else if (busy_r && timer_r == '0) begin
      if (op_r == eeprom_pkg::INS_WRITE) begin
        mem_r[addr_r] <= data_r; // [R2]
      end else if (op_r == eeprom_pkg::INS_WRITE_ALL) begin
        for (int i = 0; i < DEPTH; i++) begin
          mem_r[i] <= data_r; // [R6]
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule

/* core/eeprom_program_erase_sequencer.sv */
// Operation
// R1 - Host keeps device_select low at least min_deselect_time after a program instruction.
// R2 - Select falling after full write starts self-timed clear then store of word.
// R3 - Single-word write needs no prior erase; the cycle clears first itself.
// R4 - Select falling after full erase clears the addressed word to all ones.
// R5 - Select falling after full erase_all clears every word to all ones.
// R6 - Select falling after full write_all stores the data word everywhere.
// R7 - Internal cycle completes with no serial_clock_pin activity at all.
// R8 - Host may select and sample serial_out_pin for ready/busy; device presents it.
// R9 - While polled, serial_out_pin low while busy, high when ready.
// R10 - Frame is start bit, two-bit opcode, address, then data for writes.
// R11 - Writes and erases ignored until enable_writes since power-up or disable_writes.
// R12 - serial_in_pin sampled on each serial_clock_pin rising edge while selected.
// R13 - Select falling before frame complete discards it; no cycle starts.
// R14 - During internal cycle new instructions are refused and polls report busy.
`timescale 1ns/100ps
`include "eeprom_regs.svh"

module eeprom_program_erase_sequencer #(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES,
  parameter int unsigned ADDR_W = `ADDR_W,
  parameter int unsigned DATA_W = `DATA_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic device_select,
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe
);

  localparam int unsigned HEAD = `OPC_W + ADDR_W;
  localparam int unsigned FULL = HEAD + DATA_W;
  localparam int unsigned CNT_W = $clog2(FULL + 1);
  localparam int unsigned IDX_W = $clog2(DATA_W);

  typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_DONE, FR_READ} frame_e;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic eeprom_pkg::ins_e decode_ins(input logic [3:0] head);
    eeprom_pkg::ins_e res;
    res = eeprom_pkg::INS_NONE;
    unique case (head[3:2])
      `OPC_READ: res = eeprom_pkg::INS_READ;
      `OPC_WRITE: res = eeprom_pkg::INS_WRITE;
      `OPC_ERASE: res = eeprom_pkg::INS_ERASE;
      `OPC_SPECIAL: begin
        unique case (head[1:0])
          `SUB_ENABLE: res = eeprom_pkg::INS_ENABLE;
          `SUB_DISABLE: res = eeprom_pkg::INS_DISABLE;
          `SUB_ERASE_ALL: res = eeprom_pkg::INS_ERASE_ALL;
          `SUB_WRITE_ALL: res = eeprom_pkg::INS_WRITE_ALL;
        endcase
      end
    endcase
    return res;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Stage 0 feeds stage 1 only; edges come from stages 1 and 2
  logic [2:0] cs_sync_r;
  logic [2:0] sclk_sync_r;
  logic [1:0] sin_sync_r;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cs_sync_r <= 3'h0;
      sclk_sync_r <= 3'h0;
      sin_sync_r <= 2'h0;
    end else begin
      cs_sync_r <= {cs_sync_r[1:0], device_select};
      sclk_sync_r <= {sclk_sync_r[1:0], serial_clock_pin};
      sin_sync_r <= {sin_sync_r[0], serial_in_pin};
    end
  end

  logic cs_lvl;
  logic cs_fall;
  logic sclk_rise;
  logic sin_bit;
  assign cs_lvl = cs_sync_r[1];
  assign cs_fall = cs_sync_r[2] & ~cs_sync_r[1];
  assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2] & cs_lvl; // [R12]
  assign sin_bit = sin_sync_r[1];

  // ****************************************************************
  // Frame shifter
  // ****************************************************************
  frame_e state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [FULL-1:0] shift_r;
  logic [FULL-1:0] shift_nxt;
  logic busy;
  logic head_done;
  logic full_done;
  eeprom_pkg::ins_e ins_now;
  eeprom_pkg::ins_e ins_r;

  assign shift_nxt = {shift_r[FULL-2:0], sin_bit};
  assign head_done = sclk_rise && state_r == FR_SHIFT && cnt_r == CNT_W'(HEAD - 1);
  assign full_done = sclk_rise && state_r == FR_SHIFT && cnt_r == CNT_W'(FULL - 1);
  assign ins_now = decode_ins(shift_nxt[HEAD-1 -: 4]); // [R10]

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= FR_IDLE;
      cnt_r <= '0;
      shift_r <= '0;
    end else if (!cs_lvl) begin
      state_r <= FR_IDLE; // [R13]
      cnt_r <= '0;
    end else if (sclk_rise) begin
      unique case (state_r)
        FR_IDLE: begin
          if (sin_bit && !busy) begin
            state_r <= FR_SHIFT; // [R10] [R14]
            cnt_r <= '0;
          end
        end
        FR_SHIFT: begin
          shift_r <= shift_nxt;
          cnt_r <= cnt_r + 1'b1;
          if (head_done) begin
            if (ins_now == eeprom_pkg::INS_READ) begin
              state_r <= FR_READ;
            end else if (ins_now != eeprom_pkg::INS_WRITE && ins_now != eeprom_pkg::INS_WRITE_ALL) begin
              state_r <= FR_DONE;
            end
          end else if (full_done) begin
            state_r <= FR_DONE; // [R10]
          end
        end
        FR_DONE, FR_READ: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  // ****************************************************************
  // Decoded instruction, write enable and launch
  // ****************************************************************
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;
  logic pending_r;
  logic wen_r;
  logic start_r;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ins_r <= eeprom_pkg::INS_NONE;
      addr_r <= '0;
      data_r <= '0;
      pending_r <= 1'b0;
    end else if (!cs_lvl) begin
      pending_r <= 1'b0; // [R13]
    end else if (head_done) begin
      ins_r <= ins_now;
      addr_r <= shift_nxt[ADDR_W-1:0];
      pending_r <= ins_now == eeprom_pkg::INS_ERASE || ins_now == eeprom_pkg::INS_ERASE_ALL;
    end else if (full_done) begin
      data_r <= shift_nxt[DATA_W-1:0];
      pending_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wen_r <= 1'b0; // [R11]
    end else if (head_done && ins_now == eeprom_pkg::INS_ENABLE) begin
      wen_r <= 1'b1;
    end else if (head_done && ins_now == eeprom_pkg::INS_DISABLE) begin
      wen_r <= 1'b0;
    end
  end

  // Launch only on the select falling edge; no serial clock is needed after this
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      start_r <= 1'b0;
    end else begin
      start_r <= cs_fall && pending_r && wen_r && !busy; // [R2] [R4] [R5] [R6] [R11] [R14]
    end
  end

  logic [ADDR_W-1:0] rd_addr_r;
  logic [DATA_W-1:0] rd_data;

  eeprom_store #(
    .PROG_CYCLES(PROG_CYCLES),
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_store (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(start_r),
    .op(ins_r),
    .addr(addr_r),
    .data(data_r),
    .rd_addr(rd_addr_r),
    .rd_data(rd_data),
    .busy(busy)
  );

  // ****************************************************************
  // Output pin: status poll and read data
  // ****************************************************************
  logic status_r;
  logic [IDX_W-1:0] bit_idx_r;

  // A start bit or dummy one while ready ends status display
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status_r <= 1'b0;
    end else if (start_r) begin
      status_r <= 1'b1; // [R8]
    end else if (sclk_rise && sin_bit && !busy) begin
      status_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      serial_out_pin <= 1'b0;
      serial_out_oe <= 1'b0;
      bit_idx_r <= '0;
      rd_addr_r <= '0;
    end else if (!cs_lvl) begin
      serial_out_pin <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (head_done && ins_now == eeprom_pkg::INS_READ) begin
      serial_out_pin <= 1'b0;
      serial_out_oe <= 1'b1;
      bit_idx_r <= IDX_W'(DATA_W - 1);
      rd_addr_r <= shift_nxt[ADDR_W-1:0];
    end else if (state_r == FR_READ) begin
      if (sclk_rise) begin
        serial_out_pin <= rd_data[bit_idx_r];
        bit_idx_r <= bit_idx_r - 1'b1;
        if (bit_idx_r == '0) begin
          rd_addr_r <= rd_addr_r + 1'b1;
        end
      end
    end else if (status_r) begin
      serial_out_pin <= ~busy; // [R8] [R9] [R14]
      serial_out_oe <= 1'b1;
    end else begin
      serial_out_oe <= 1'b0;
    end
  end

endmodule

/* sim/eeprom_seq_properties.sv */
`timescale 1ns/100ps
module eeprom_seq_properties #(
  parameter int unsigned PROG_CYCLES = 200
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic device_select,
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe
);
  // ****************************************
  // Status is told from read data by a long idle link clock
  // ****************************************
  logic sclk_r;
  logic [7:0] quiet_r;
  logic rdy_r;
  logic busy_r;
  int unsigned busy_cnt_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge sys_clk) begin
    sclk_r <= serial_clock_pin;
    if (sys_rst || serial_clock_pin != sclk_r) quiet_r <= 8'h00;
    else if (quiet_r != 8'hFF) quiet_r <= quiet_r + 8'h01;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !serial_out_oe) rdy_r <= 1'b0;
    else if (serial_out_pin && quiet_r > 8'h14) rdy_r <= 1'b1;
  end
  // Busy seen on a poll must clear within the cycle length plus poll spacing
  always_ff @(posedge sys_clk) begin
    if (sys_rst || (serial_out_oe && serial_out_pin)) busy_r <= 1'b0;
    else if (serial_out_oe && quiet_r > 8'h14) busy_r <= 1'b1;
  end
  always_ff @(posedge sys_clk) begin
    if (!busy_r) busy_cnt_r <= 0;
    else busy_cnt_r <= busy_cnt_r + 1;
  end
  AST_RST_QUIET: assert property ($fell(sys_rst) |-> !serial_out_oe && !serial_out_pin)
    else $error("data-out active after reset");
  AST_DESEL_RELEASE: assert property (!device_select [*6] |-> !serial_out_oe)
    else $error("data-out driven while deselected");
  AST_OE_NEEDS_SEL: assert property ($rose(serial_out_oe) |-> $past(device_select, 2))
    else $error("data-out enabled without select");
  AST_BUSY_BOUNDED: assert property (busy_cnt_r <= PROG_CYCLES + 64)
    else $error("busy status lasts too long");
  AST_READY_STICKS: assert property (rdy_r && device_select && quiet_r > 8'h14 |=> serial_out_pin || !serial_out_oe)
    else $error("ready status fell back to busy");
  AST_DUMMY_ONE: assert property (rdy_r && device_select && $rose(serial_clock_pin) && serial_in_pin
    |-> ##[1:8] !serial_out_oe)
    else $error("dummy one did not release data-out");
  AST_OE_HOLDS: assert property (device_select [*6] ##0 (serial_out_oe && quiet_r > 8'h14) |=> serial_out_oe)
    else $error("status vanished while selected");
  AST_OE_STAYS_OFF: assert property (device_select [*8] ##0 (!serial_out_oe && quiet_r > 8'h14) |=> !serial_out_oe)
    else $error("data-out enabled with idle clock");
endmodule
bind eeprom_program_erase_sequencer eeprom_seq_properties #(.PROG_CYCLES(PROG_CYCLES)) chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .device_select(device_select), .serial_clock_pin(serial_clock_pin),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe));

/* sim/link_host.sv */
`timescale 1ns/100ps
module link_host (
  output logic device_select,
  output logic serial_clock_pin,
  output logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe
);
  // ****************************************
  // Link clock stands low outside frames; idle data toggles so no stale bit is read
  // ****************************************
  initial begin
    device_select = 1'b0;
    serial_clock_pin = 1'b0;
    serial_in_pin = 1'b0;
  end
  task automatic bit_out(input logic b);
    serial_in_pin = b;
    #62.5;
    serial_clock_pin = 1'b1;
    #62.5;
    serial_clock_pin = 1'b0;
  endtask
  task automatic release_link();
    device_select = 1'b0;
    serial_in_pin = ~serial_in_pin;
    #100;
  endtask
  task automatic xfer(input logic [26:0] f, input int n);
    device_select = 1'b1;
    for (int i = 26; i > 26 - n; i--) bit_out(f[i]);
    #62.5;
    release_link();
  endtask
  task automatic poll(output logic oe, output logic lvl);
    device_select = 1'b1;
    #200;
    oe = serial_out_oe;
    lvl = serial_out_pin;
    if (oe && lvl) bit_out(1'b1);
    release_link();
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    logic [10:0] f;
    f = {3'b110, a};
    device_select = 1'b1;
    for (int i = 10; i >= 0; i--) bit_out(f[i]);
    for (int i = 15; i >= 0; i--) begin
      bit_out(1'b0);
      // A released data-out line must not pass for valid data
      d[i] = serial_out_oe ? serial_out_pin : ~serial_out_pin;
    end
    release_link();
  endtask
endmodule

/* sim/eeprom_program_erase_sequencer_bench.sv */
`timescale 1ns/100ps
module eeprom_program_erase_sequencer_bench;
  localparam int unsigned PROG_CYCLES = 1000;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  wire device_select;
  wire serial_clock_pin;
  wire serial_in_pin;
  logic serial_out_pin;
  logic serial_out_oe;
  logic [15:0] mem [256];
  logic [7:0] a;
  logic [15:0] dd;
  logic en = 1'b0;
  int err_count = 0;
  int compares = 0;
  int seed = 33;
  always #4 sys_clk = ~sys_clk;
  eeprom_program_erase_sequencer #(.PROG_CYCLES(PROG_CYCLES)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .device_select(device_select), .serial_clock_pin(serial_clock_pin), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe));
  link_host host (.device_select(device_select), .serial_clock_pin(serial_clock_pin),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe));
  // ****************************************
  // Checking and model
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] ra);
    logic [15:0] got;
    host.rd(ra, got);
    check("read word", got, mem[ra]);
  endtask
  // First poll must show busy; bounded wait for ready with no link clock while busy, then one dummy one is clocked on the ready poll
  task automatic settle();
    logic oe;
    logic lvl;
    int n;
    host.poll(oe, lvl);
    check("poll busy", {14'h0000, oe, lvl}, 16'h0002);
    n = 0;
    while (!(oe && lvl) && n < 60) begin
      host.poll(oe, lvl);
      n++;
    end
    check("poll ready", {14'h0000, oe, lvl}, 16'h0003);
  endtask
  task automatic prog(input logic [1:0] op, input logic [7:0] pa, input logic [15:0] dat, input int n);
    int full;
    full = (op == 2'h1 || (op == 2'h0 && pa[7:6] == 2'h1)) ? 27 : 11;
    host.xfer({1'b1, op, pa, dat}, n);
    if (n < full) return;
    if (op == 2'h0 && pa[7] == pa[6]) en = pa[7];
    else if (en) begin
      if (op == 2'h1) mem[pa] = dat;
      else if (op == 2'h3) mem[pa] = 16'hFFFF;
      else for (int k = 0; k < 256; k++) mem[k] = pa[7] ? 16'hFFFF : dat;
      settle();
    end
  endtask
  initial begin
    #500000;
    err_count++;
    wrap_up();
  end
  initial begin
    for (int k = 0; k < 256; k++) mem[k] = 16'hFFFF;
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    a = 8'($random(seed));
    dd = 16'($random(seed));
    prog(2'h1, a, dd, 27);
    rd(a);
    prog(2'h0, 8'hC0, 16'h0000, 11);
    prog(2'h1, a, dd, 20);
    rd(a);
    prog(2'h1, a, dd, 27);
    rd(a);
    prog(2'h1, a, ~dd, 27);
    rd(a);
    host.xfer({3'b101, a + 8'h01, dd}, 27);
    host.xfer({3'b101, a + 8'h02, ~dd}, 27);
    mem[a + 8'h01] = dd;
    settle();
    rd(a + 8'h01);
    rd(a + 8'h02);
    prog(2'h3, a, 16'h0000, 11);
    rd(a);
    prog(2'h0, 8'h40, dd, 27);
    rd(8'h00);
    rd(8'hFF);
    prog(2'h0, 8'h80, 16'h0000, 11);
    rd(8'h00);
    rd(a);
    repeat (3) begin
      a = 8'($random(seed));
      dd = 16'($random(seed));
      prog(2'h1, a, dd, 27);
      rd(a);
    end
    prog(2'h0, 8'h00, 16'h0000, 11);
    prog(2'h3, a, 16'h0000, 11);
    rd(a);
    wrap_up();
  end
endmodule
